// file: fttor_defs.vh
/*
   Register offsets, field positions, reset values and code tables of the
   fan threshold and temperature offset register bank.
   Assumes it is included by bare name, once or more, by the design files.
*/
`ifndef FTTOR_DEFS_VH
`define FTTOR_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define FTTOR_ADDR_LOCAL_OFFSET      8'h0d
`define FTTOR_ADDR_REMOTE1_OFFSET    8'h0e
`define FTTOR_ADDR_REMOTE2_OFFSET    8'h0f
`define FTTOR_ADDR_LOCAL_THRESH      8'h24
`define FTTOR_ADDR_REMOTE1_THRESH    8'h25
`define FTTOR_ADDR_REMOTE2_THRESH    8'h26
`define FTTOR_ADDR_ALARM_REV         8'h3f

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define FTTOR_START_MSB              7
`define FTTOR_START_LSB              3
`define FTTOR_SPAN_MSB               2
`define FTTOR_SPAN_LSB               0
`define FTTOR_OFFSET_SIGN_BIT        7
`define FTTOR_OFFSET_MAG_MSB         3
`define FTTOR_OFFSET_MAG_LSB         0
`define FTTOR_ALARM_EN_BIT           7
`define FTTOR_REV_MSB                3
`define FTTOR_REV_LSB                0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define FTTOR_RST_LOCAL_THRESH       8'h41
`define FTTOR_RST_REMOTE_THRESH      8'h61
`define FTTOR_RST_OFFSET             8'h00
`define FTTOR_RST_ALARM_EN           1'b1
`define FTTOR_RDATA_UNMAPPED         8'h00

// ----------------------------------------------------------------------------
// span codes, span degrees, full duty
// ----------------------------------------------------------------------------
`define FTTOR_SPAN_CODE_5C           3'h0
`define FTTOR_SPAN_CODE_10C          3'h1
`define FTTOR_SPAN_CODE_20C          3'h2
`define FTTOR_SPAN_CODE_40C          3'h3
`define FTTOR_SPAN_DEG_5C            7'h05
`define FTTOR_SPAN_DEG_10C           7'h0a
`define FTTOR_SPAN_DEG_20C           7'h14
`define FTTOR_SPAN_DEG_40C           7'h28
`define FTTOR_SPAN_DEG_80C           7'h50
`define FTTOR_DUTY_FULL              4'hf

`endif

// file: fttor_chan.v
/*
   One temperature channel: applies the signed offset to the reading and
   turns the corrected reading into a fan demand of 0 to 15 against the
   channel's start temperature and span.
   Assumes readings are whole degrees, two's complement, steady per cycle.
*/
`timescale 1ns/1ps
`include "fttor_defs.vh"

module fttor_chan (
   input wire [7:0] temp_raw,              // reading, signed whole degrees
   input wire offset_sign,                 // 1 subtracts the magnitude
   input wire [3:0] offset_mag,            // offset magnitude, degrees
   input wire [4:0] fan_start_temperature, // start code, 4 degree steps
   input wire [2:0] fan_control_span,      // span code
   output reg [7:0] temp_corrected,        // offset-corrected reading
   output reg [3:0] demand                 // 0 at start, 15 at start+span
);

reg signed [9:0] sum;
reg signed [9:0] diff;
reg [6:0] span_deg;
reg [10:0] scaled;
reg [10:0] quot;

always @* begin
   sum = {{2{temp_raw[7]}}, temp_raw};
   // ----------------------------------------------------------------------
   // offset correction, saturated to the reading's range
   // ----------------------------------------------------------------------
   if (offset_sign) begin                                // [RL9] [RL11]
      sum = sum - $signed({6'h00, offset_mag});          // [RL10]
   end else begin
      sum = sum + $signed({6'h00, offset_mag});          // [RL10]
   end
   if (sum > $signed(10'h07f)) begin
      temp_corrected = 8'h7f;
   end else if (sum < $signed(10'h380)) begin
      temp_corrected = 8'h80;
   end else begin
      temp_corrected = sum[7:0];
   end
   // ----------------------------------------------------------------------
   // span decode; spare codes act as the widest span
   // ----------------------------------------------------------------------
   case (fan_control_span)                               // [RL2]
      `FTTOR_SPAN_CODE_5C: span_deg = `FTTOR_SPAN_DEG_5C;
      `FTTOR_SPAN_CODE_10C: span_deg = `FTTOR_SPAN_DEG_10C;
      `FTTOR_SPAN_CODE_20C: span_deg = `FTTOR_SPAN_DEG_20C;
      `FTTOR_SPAN_CODE_40C: span_deg = `FTTOR_SPAN_DEG_40C;
      default: span_deg = `FTTOR_SPAN_DEG_80C;
   endcase
   // start code is unsigned, so only starts of zero or above exist
   diff = {{2{temp_corrected[7]}}, temp_corrected} - $signed({3'h0, fan_start_temperature, 2'h0}); // [RL1]
   scaled = 11'h000;
   quot = 11'h000;
   if (diff < $signed(10'h000)) begin
      demand = 4'h0;
   end else if (diff >= $signed({3'h0, span_deg})) begin
      demand = `FTTOR_DUTY_FULL;                         // [RL15]
   end else begin
      scaled = {4'h0, diff[6:0]} * 11'h00f;
      quot = scaled / {4'h0, span_deg};
      demand = quot[3:0];                                // [RL15]
   end
end

endmodule // fttor_chan

// file: fttor_regs.v
/*
   Fan threshold, temperature offset and alarm behaviour register bank with
   the automatic fan duty computation that those registers steer.
   Assumes a serial-bus engine in front presents byte reads and writes on
   the register port, and readings arrive already converted, synchronous.
*/
`timescale 1ns/1ps
`include "fttor_defs.vh"

// How it works
// RL1: start temperature in bits 7:3, 4 degree steps
// RL2: span in bits 2:0, 5 to 80 degrees
// RL3: local threshold resets to 0x41
// RL4: both remote thresholds reset to 0x61
// RL5: each threshold compares its own channel reading
// RL6: enable set forces full speed on alarm
// RL7: enable clear leaves fan speed alone (silent)
// RL8: revision nibble read-only, writes ignored
// RL9: local offset added, or subtracted when sign set
// RL10: 4-bit magnitude, up to 15 degrees correction
// RL11: remote offsets add or subtract by sign bit
// RL12: remote offset bits 6:4 read zero
// RL13: all offset registers reset to 0x00
// RL14: speed nibble is the automatic-mode minimum speed
// RL15: duty climbs from minimum to full over span
module fttor_regs #(
   parameter [3:0] REVISION_ID = 4'h3      // arbitrary value
) (
   input wire clock,                       // system clock, 250 MHz
   input wire srst,                        // synchronous reset, active high
   input wire [7:0] reg_addr,              // register offset
   input wire reg_wr_en,                   // write strobe, one cycle
   input wire [7:0] reg_wdata,             // write data
   input wire reg_rd_en,                   // read strobe, one cycle
   input wire [7:0] local_temp,            // local reading, signed degrees
   input wire [7:0] remote1_temp,          // remote 1 reading
   input wire [7:0] remote2_temp,          // remote 2 reading
   input wire overtemp_alarm_pin_n,        // alarm pin level, low = asserted
   input wire auto_fan_mode,               // 1 = automatic speed control
   input wire [3:0] fan1_min_speed,        // fan 1 speed nibble
   input wire [3:0] fan2_min_speed,        // fan 2 speed nibble
   output reg [7:0] reg_rdata_ff,          // read data
   output reg reg_rvalid_ff,               // read data valid, one cycle
   output reg [7:0] local_temp_corr_ff,    // corrected local reading
   output reg [7:0] remote1_temp_corr_ff,  // corrected remote 1 reading
   output reg [7:0] remote2_temp_corr_ff,  // corrected remote 2 reading
   output reg [3:0] fan1_duty_ff,          // fan 1 duty, 15 = full
   output reg [3:0] fan2_duty_ff,          // fan 2 duty, 15 = full
   output reg full_speed_forced_ff         // alarm is forcing full speed
);

// ----------------------------------------------------------------------------
// storage
// ----------------------------------------------------------------------------
reg local_offset_sign_ff;
reg [3:0] local_offset_mag_ff;
reg remote1_offset_sign_ff;
reg [3:0] remote1_offset_mag_ff;
reg remote2_offset_sign_ff;
reg [3:0] remote2_offset_mag_ff;
reg [7:0] local_thresh_ff;
reg [7:0] remote1_thresh_ff;
reg [7:0] remote2_thresh_ff;
reg full_speed_on_alarm_enable_ff;

// a literal cannot be bit-selected, so the reset image is named first
localparam [7:0] RST_OFFSET = `FTTOR_RST_OFFSET;

reg [7:0] nxt_rdata;
reg [3:0] nxt_demand;
reg nxt_forced;
reg [3:0] nxt_fan1_duty;
reg [3:0] nxt_fan2_duty;

wire [7:0] local_corr;
wire [7:0] remote1_corr;
wire [7:0] remote2_corr;
wire [3:0] local_demand;
wire [3:0] remote1_demand;
wire [3:0] remote2_demand;

wire wr_local_offset;
wire wr_remote1_offset;
wire wr_remote2_offset;
wire wr_local_thresh;
wire wr_remote1_thresh;
wire wr_remote2_thresh;
wire wr_alarm_rev;

// ----------------------------------------------------------------------------
// write decode
// ----------------------------------------------------------------------------
assign wr_local_offset = reg_wr_en && (reg_addr == `FTTOR_ADDR_LOCAL_OFFSET);
assign wr_remote1_offset = reg_wr_en && (reg_addr == `FTTOR_ADDR_REMOTE1_OFFSET);
assign wr_remote2_offset = reg_wr_en && (reg_addr == `FTTOR_ADDR_REMOTE2_OFFSET);
assign wr_local_thresh = reg_wr_en && (reg_addr == `FTTOR_ADDR_LOCAL_THRESH);
assign wr_remote1_thresh = reg_wr_en && (reg_addr == `FTTOR_ADDR_REMOTE1_THRESH);
assign wr_remote2_thresh = reg_wr_en && (reg_addr == `FTTOR_ADDR_REMOTE2_THRESH);
assign wr_alarm_rev = reg_wr_en && (reg_addr == `FTTOR_ADDR_ALARM_REV);

// ----------------------------------------------------------------------------
// offset registers
// ----------------------------------------------------------------------------
// bits 6:4 are not stored at all, so they cannot read back anything but zero
always @(posedge clock) begin
   if (srst) begin
      local_offset_sign_ff <= RST_OFFSET[`FTTOR_OFFSET_SIGN_BIT];             // [RL13]
      local_offset_mag_ff <= RST_OFFSET[`FTTOR_OFFSET_MAG_MSB:`FTTOR_OFFSET_MAG_LSB];
      remote1_offset_sign_ff <= RST_OFFSET[`FTTOR_OFFSET_SIGN_BIT];           // [RL13]
      remote1_offset_mag_ff <= RST_OFFSET[`FTTOR_OFFSET_MAG_MSB:`FTTOR_OFFSET_MAG_LSB];
      remote2_offset_sign_ff <= RST_OFFSET[`FTTOR_OFFSET_SIGN_BIT];           // [RL13]
      remote2_offset_mag_ff <= RST_OFFSET[`FTTOR_OFFSET_MAG_MSB:`FTTOR_OFFSET_MAG_LSB];
   end else begin
      if (wr_local_offset) begin
         local_offset_sign_ff <= reg_wdata[`FTTOR_OFFSET_SIGN_BIT];           // [RL9]
         local_offset_mag_ff <= reg_wdata[`FTTOR_OFFSET_MAG_MSB:`FTTOR_OFFSET_MAG_LSB]; // [RL10]
      end
      if (wr_remote1_offset) begin
         remote1_offset_sign_ff <= reg_wdata[`FTTOR_OFFSET_SIGN_BIT];         // [RL11]
         remote1_offset_mag_ff <= reg_wdata[`FTTOR_OFFSET_MAG_MSB:`FTTOR_OFFSET_MAG_LSB]; // [RL10]
      end
      if (wr_remote2_offset) begin
         remote2_offset_sign_ff <= reg_wdata[`FTTOR_OFFSET_SIGN_BIT];         // [RL11]
         remote2_offset_mag_ff <= reg_wdata[`FTTOR_OFFSET_MAG_MSB:`FTTOR_OFFSET_MAG_LSB]; // [RL10]
      end
   end
end

// ----------------------------------------------------------------------------
// threshold and alarm behaviour registers
// ----------------------------------------------------------------------------
always @(posedge clock) begin
   if (srst) begin
      local_thresh_ff <= `FTTOR_RST_LOCAL_THRESH;                  // [RL3]
      remote1_thresh_ff <= `FTTOR_RST_REMOTE_THRESH;               // [RL4]
      remote2_thresh_ff <= `FTTOR_RST_REMOTE_THRESH;               // [RL4]
      full_speed_on_alarm_enable_ff <= `FTTOR_RST_ALARM_EN;        // [RL6]
   end else begin
      if (wr_local_thresh) begin
         local_thresh_ff <= reg_wdata;                             // [RL1] [RL2]
      end
      if (wr_remote1_thresh) begin
         remote1_thresh_ff <= reg_wdata;                           // [RL1] [RL2]
      end
      if (wr_remote2_thresh) begin
         remote2_thresh_ff <= reg_wdata;                           // [RL1] [RL2]
      end
      // only the enable is stored; the revision nibble has no storage
      if (wr_alarm_rev) begin
         full_speed_on_alarm_enable_ff <= reg_wdata[`FTTOR_ALARM_EN_BIT]; // [RL8]
      end
   end
end

// ----------------------------------------------------------------------------
// read path
// ----------------------------------------------------------------------------
always @* begin
   nxt_rdata = `FTTOR_RDATA_UNMAPPED;
   case (reg_addr)
      `FTTOR_ADDR_LOCAL_OFFSET: begin
         nxt_rdata = {local_offset_sign_ff, 3'h0, local_offset_mag_ff};
      end
      `FTTOR_ADDR_REMOTE1_OFFSET: begin
         nxt_rdata = {remote1_offset_sign_ff, 3'h0, remote1_offset_mag_ff};   // [RL12]
      end
      `FTTOR_ADDR_REMOTE2_OFFSET: begin
         nxt_rdata = {remote2_offset_sign_ff, 3'h0, remote2_offset_mag_ff};   // [RL12]
      end
      `FTTOR_ADDR_LOCAL_THRESH: begin
         nxt_rdata = local_thresh_ff;
      end
      `FTTOR_ADDR_REMOTE1_THRESH: begin
         nxt_rdata = remote1_thresh_ff;
      end
      `FTTOR_ADDR_REMOTE2_THRESH: begin
         nxt_rdata = remote2_thresh_ff;
      end
      `FTTOR_ADDR_ALARM_REV: begin
         nxt_rdata = {full_speed_on_alarm_enable_ff, 3'h0, REVISION_ID};     // [RL8]
      end
      default: begin
         nxt_rdata = `FTTOR_RDATA_UNMAPPED;
      end
   endcase
end

always @(posedge clock) begin
   if (srst) begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
   end else begin
      reg_rvalid_ff <= reg_rd_en;
      if (reg_rd_en) begin
         reg_rdata_ff <= nxt_rdata;
      end
   end
end

// ----------------------------------------------------------------------------
// per-channel correction and demand
// ----------------------------------------------------------------------------
// each channel sees its own threshold register only
fttor_chan u_local_chan (                                          // [RL5]
   .temp_raw(local_temp),
   .offset_sign(local_offset_sign_ff),
   .offset_mag(local_offset_mag_ff),
   .fan_start_temperature(local_thresh_ff[`FTTOR_START_MSB:`FTTOR_START_LSB]),
   .fan_control_span(local_thresh_ff[`FTTOR_SPAN_MSB:`FTTOR_SPAN_LSB]),
   .temp_corrected(local_corr),
   .demand(local_demand)
);

fttor_chan u_remote1_chan (                                        // [RL5]
   .temp_raw(remote1_temp),
   .offset_sign(remote1_offset_sign_ff),
   .offset_mag(remote1_offset_mag_ff),
   .fan_start_temperature(remote1_thresh_ff[`FTTOR_START_MSB:`FTTOR_START_LSB]),
   .fan_control_span(remote1_thresh_ff[`FTTOR_SPAN_MSB:`FTTOR_SPAN_LSB]),
   .temp_corrected(remote1_corr),
   .demand(remote1_demand)
);

fttor_chan u_remote2_chan (                                        // [RL5]
   .temp_raw(remote2_temp),
   .offset_sign(remote2_offset_sign_ff),
   .offset_mag(remote2_offset_mag_ff),
   .fan_start_temperature(remote2_thresh_ff[`FTTOR_START_MSB:`FTTOR_START_LSB]),
   .fan_control_span(remote2_thresh_ff[`FTTOR_SPAN_MSB:`FTTOR_SPAN_LSB]),
   .temp_corrected(remote2_corr),
   .demand(remote2_demand)
);

// ----------------------------------------------------------------------------
// duty computation
// ----------------------------------------------------------------------------
// scales demand 0..15 onto the band between the minimum and full speed
function [3:0] fttor_duty;
   input [3:0] min_speed;
   input [3:0] demand;
   input auto_mode;
   input forced;
   reg [7:0] prod;
   reg [7:0] step;
   begin
      prod = {4'h0, (`FTTOR_DUTY_FULL - min_speed)} * {4'h0, demand};
      step = prod / 8'h0f;
      if (forced) begin
         fttor_duty = `FTTOR_DUTY_FULL;                    // [RL6]
      end else if (!auto_mode) begin
         fttor_duty = min_speed;
      end else begin
         fttor_duty = min_speed + step[3:0];               // [RL14] [RL15]
      end
   end
endfunction

always @* begin
   // the hottest channel, relative to its own band, sets the demand
   nxt_demand = local_demand;
   if (remote1_demand > nxt_demand) begin
      nxt_demand = remote1_demand;
   end
   if (remote2_demand > nxt_demand) begin
      nxt_demand = remote2_demand;
   end
   // with the enable clear the alarm pin has no say: silent mode
   nxt_forced = full_speed_on_alarm_enable_ff && !overtemp_alarm_pin_n; // [RL6] [RL7]
   nxt_fan1_duty = fttor_duty(fan1_min_speed, nxt_demand, auto_fan_mode, nxt_forced);
   nxt_fan2_duty = fttor_duty(fan2_min_speed, nxt_demand, auto_fan_mode, nxt_forced);
end

// ----------------------------------------------------------------------------
// output registers
// ----------------------------------------------------------------------------
// one cycle of latency from reading or register change to duty
always @(posedge clock) begin
   if (srst) begin
      local_temp_corr_ff <= 8'h00;
      remote1_temp_corr_ff <= 8'h00;
      remote2_temp_corr_ff <= 8'h00;
      fan1_duty_ff <= 4'h0;
      fan2_duty_ff <= 4'h0;
      full_speed_forced_ff <= 1'b0;
   end else begin
      local_temp_corr_ff <= local_corr;                    // [RL9]
      remote1_temp_corr_ff <= remote1_corr;                // [RL11]
      remote2_temp_corr_ff <= remote2_corr;                // [RL11]
      fan1_duty_ff <= nxt_fan1_duty;
      fan2_duty_ff <= nxt_fan2_duty;
      full_speed_forced_ff <= nxt_forced;                  // [RL6] [RL7]
   end
end

endmodule // fttor_regs

// file: fttor_regs_asserts.sv
/*
   Checker for the fan threshold and offset register bank, bound to fttor_regs.
   Assumes it sees only the top ports, one clock, synchronous reset.
*/
`timescale 1ns/1ps

module fttor_asserts #(
   parameter [3:0] REVISION_ID = 4'h3 // arbitrary value
) (
   input wire clock, // clock
   input wire srst, // reset
   input wire [7:0] reg_addr, // offset
   input wire reg_wr_en, // write
   input wire [7:0] reg_wdata, // wdata
   input wire reg_rd_en, // read
   input wire [7:0] local_temp, // reading
   input wire [7:0] remote1_temp, // reading
   input wire [7:0] remote2_temp, // reading
   input wire overtemp_alarm_pin_n, // alarm
   input wire auto_fan_mode, // mode
   input wire [3:0] fan1_min_speed, // nibble
   input wire [3:0] fan2_min_speed, // nibble
   input wire [7:0] reg_rdata_ff, // rdata
   input wire reg_rvalid_ff, // rvalid
   input wire [7:0] local_temp_corr_ff, // corrected
   input wire [7:0] remote1_temp_corr_ff, // corrected
   input wire [7:0] remote2_temp_corr_ff, // corrected
   input wire [3:0] fan1_duty_ff, // duty
   input wire [3:0] fan2_duty_ff, // duty
   input wire full_speed_forced_ff // forced
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_read(a); reg_rd_en && reg_addr == a; endsequence

   property p_read_valid; reg_rd_en |=> reg_rvalid_ff; endproperty
   a_read_valid: assert property (p_read_valid)
      else $error("read strobe gave no valid pulse");
   property p_read_quiet; !reg_rd_en |=> !reg_rvalid_ff && $stable(reg_rdata_ff); endproperty
   a_read_quiet: assert property (p_read_quiet)
      else $error("read data moved without a read");
   property p_rev_read; s_read(8'h3f) |=> reg_rdata_ff[6:0] == {3'b000, REVISION_ID}; endproperty
   a_rev_read: assert property (p_rev_read)
      else $error("revision field wrong");
   property p_remote_unused; (s_read(8'h0e) or s_read(8'h0f)) |=> reg_rdata_ff[6:4] == 3'b000; endproperty
   a_remote_unused: assert property (p_remote_unused)
      else $error("remote offset unused bits not zero");
   property p_forced_full; full_speed_forced_ff |-> fan1_duty_ff == 4'hf && fan2_duty_ff == 4'hf; endproperty
   a_forced_full: assert property (p_forced_full)
      else $error("forced but duty not full");
   property p_forced_cause; overtemp_alarm_pin_n |=> !full_speed_forced_ff; endproperty
   a_forced_cause: assert property (p_forced_cause)
      else $error("forced without alarm");
   property p_manual_duty;
      !auto_fan_mode && overtemp_alarm_pin_n |=>
         fan1_duty_ff == $past(fan1_min_speed) && fan2_duty_ff == $past(fan2_min_speed);
   endproperty
   a_manual_duty: assert property (p_manual_duty)
      else $error("manual duty differs from nibble");
   property p_auto_floor; auto_fan_mode && overtemp_alarm_pin_n |=> fan1_duty_ff >= $past(fan1_min_speed); endproperty
   a_auto_floor: assert property (p_auto_floor)
      else $error("auto duty below minimum");
endmodule // fttor_asserts

bind fttor_regs fttor_asserts #(.REVISION_ID(REVISION_ID)) i_fttor_asserts (
   .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
   .reg_rd_en(reg_rd_en), .local_temp(local_temp), .remote1_temp(remote1_temp), .remote2_temp(remote2_temp),
   .overtemp_alarm_pin_n(overtemp_alarm_pin_n), .auto_fan_mode(auto_fan_mode), .fan1_min_speed(fan1_min_speed),
   .fan2_min_speed(fan2_min_speed), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
   .local_temp_corr_ff(local_temp_corr_ff), .remote1_temp_corr_ff(remote1_temp_corr_ff),
   .remote2_temp_corr_ff(remote2_temp_corr_ff), .fan1_duty_ff(fan1_duty_ff), .fan2_duty_ff(fan2_duty_ff),
   .full_speed_forced_ff(full_speed_forced_ff));

// file: fttor_regs_tb.sv
/*
   Self-checking testbench of the fan threshold and offset register bank.
   Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ps

module fttor_regs_tb;
   localparam [3:0] REV = 4'h5; // arbitrary value
   reg clock, srst, reg_wr_en, reg_rd_en, pin_n, auto_mode;
   reg [7:0] reg_addr, reg_wdata, t_loc, t_r1, t_r2;
   reg [3:0] min1, min2;
   wire [7:0] rdata, c_loc, c_r1, c_r2;
   wire rvalid, forced;
   wire [3:0] duty1, duty2;
   integer num_errors, compares, c;
   reg [7:0] spans [0:4];

   fttor_regs #(.REVISION_ID(REV)) i_fttor_regs (.clock(clock), .srst(srst), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .local_temp(t_loc),
      .remote1_temp(t_r1), .remote2_temp(t_r2), .overtemp_alarm_pin_n(pin_n), .auto_fan_mode(auto_mode),
      .fan1_min_speed(min1), .fan2_min_speed(min2), .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid),
      .local_temp_corr_ff(c_loc), .remote1_temp_corr_ff(c_r1), .remote2_temp_corr_ff(c_r2),
      .fan1_duty_ff(duty1), .fan2_duty_ff(duty2), .full_speed_forced_ff(forced));

   // ---------------------------------------------------------------------
   // drivers and compares
   // ---------------------------------------------------------------------
   task chk_byte(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task chk_duty(input [3:0] d1, input [3:0] d2, input [3:0] e1, input [3:0] e2);
      begin
         chk_byte({4'h0, d1}, {4'h0, e1});
         chk_byte({4'h0, d2}, {4'h0, e2});
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clock) #1 reg_wr_en = 1'b1; reg_addr = a; reg_wdata = d;
         @(posedge clock) #1 reg_wr_en = 1'b0;
      end
   endtask
   // rvalid stands one cycle, so it is looked at right after its edge
   task rd_chk(input [7:0] a, input [7:0] exp);
      begin
         @(posedge clock) #1 reg_rd_en = 1'b1; reg_addr = a;
         @(posedge clock) #1 reg_rd_en = 1'b0;
         chk_byte({7'h00, rvalid}, 8'h01);
         chk_byte(rdata, exp);
      end
   endtask
   task settle;
      begin
         repeat (3) @(posedge clock);
         #1;
      end
   endtask
   task give_verdict;
      begin
         if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   // ---------------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------------
   task t_reset_vals;
      begin
         rd_chk(8'h0d, 8'h00);
         rd_chk(8'h0e, 8'h00);
         rd_chk(8'h0f, 8'h00);
         rd_chk(8'h24, 8'h41);
         rd_chk(8'h25, 8'h61);
         rd_chk(8'h26, 8'h61);
         rd_chk(8'h3f, {4'h8, REV});
      end
   endtask
   task t_regs;
      begin
         wr(8'h24, 8'h52);
         rd_chk(8'h24, 8'h52);
         wr(8'h0e, 8'hff);
         rd_chk(8'h0e, 8'h8f);
         wr(8'h0f, 8'h7a);
         rd_chk(8'h0f, 8'h0a);
         wr(8'h3f, 8'h0f);
         rd_chk(8'h3f, {4'h0, REV});
         wr(8'h3f, 8'hf0);
         rd_chk(8'h3f, {4'h8, REV});
         wr(8'h10, 8'hff);
         rd_chk(8'h10, 8'h00);
         wr(8'h24, 8'h41);
         wr(8'h0e, 8'h00);
         wr(8'h0f, 8'h00);
      end
   endtask
   task t_alarm;
      begin
         auto_mode = 1'b0; min1 = 4'h3; min2 = 4'h6; pin_n = 1'b0;
         settle;
         chk_byte({7'h00, forced}, 8'h01);
         chk_duty(duty1, duty2, 4'hf, 4'hf);
         wr(8'h3f, 8'h00);
         settle;
         chk_byte({7'h00, forced}, 8'h00);
         chk_duty(duty1, duty2, 4'h3, 4'h6);
         wr(8'h3f, 8'h80);
         pin_n = 1'b1;
      end
   endtask
   task t_offset;
      begin
         t_loc = 8'd20; t_r1 = 8'd30; t_r2 = 8'd40;
         wr(8'h0d, 8'h05);
         settle;
         chk_byte(c_loc, 8'd25);
         wr(8'h0d, 8'h8f);
         wr(8'h0e, 8'h8f);
         wr(8'h0f, 8'h0f);
         settle;
         chk_byte(c_loc, 8'd5);
         chk_byte(c_r1, 8'd15);
         chk_byte(c_r2, 8'd55);
         wr(8'h0d, 8'h00);
         wr(8'h0e, 8'h00);
         wr(8'h0f, 8'h00);
      end
   endtask
   task t_auto;
      begin
         auto_mode = 1'b1; min1 = 4'h0; min2 = 4'h0; t_loc = 8'd60; t_r1 = 8'd0; t_r2 = 8'd0;
         wr(8'h24, 8'hf8);
         settle;
         chk_duty(duty1, duty2, 4'h0, 4'h0);
         t_r2 = 8'd53;
         settle;
         chk_duty(duty1, duty2, 4'h7, 4'h7);
         t_r2 = 8'd0;
         for (c = 0; c < 5; c = c + 1) begin
            wr(8'h24, {5'd1, c[2:0]});
            t_loc = 8'd4 + spans[c];
            settle;
            chk_duty(duty1, duty2, 4'hf, 4'hf);
            t_loc = 8'd3 + spans[c];
            settle;
            chk_duty(duty1, duty2, (spans[c] - 1) * 15 / spans[c], (spans[c] - 1) * 15 / spans[c]);
            t_loc = 8'd3;
            settle;
            chk_duty(duty1, duty2, 4'h0, 4'h0);
         end
         wr(8'h24, 8'hf8);
         t_loc = 8'd127;
         settle;
         chk_duty(duty1, duty2, 4'h9, 4'h9);
         wr(8'h24, 8'h41);
         min1 = 4'h4; min2 = 4'h9; t_loc = 8'd37;
         settle;
         chk_duty(duty1, duty2, 4'h9, 4'hb);
      end
   endtask

   // ---------------------------------------------------------------------
   // clock, reset, sequence, watchdog
   // ---------------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      srst = 1'b1; reg_wr_en = 1'b0; reg_rd_en = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      t_loc = 8'h00; t_r1 = 8'h00; t_r2 = 8'h00; pin_n = 1'b1; auto_mode = 1'b0;
      min1 = 4'h5; min2 = 4'h5; num_errors = 0; compares = 0;
      spans[0] = 8'd5; spans[1] = 8'd10; spans[2] = 8'd20; spans[3] = 8'd40; spans[4] = 8'd80;
      repeat (16) @(posedge clock);
      #1 srst = 1'b0;
      t_reset_vals;
      t_regs;
      t_alarm;
      t_offset;
      t_auto;
      give_verdict;
   end
   // whole run is well under a thousand cycles
   initial begin
      #40000;
      num_errors = num_errors + 1;
      give_verdict;
   end
endmodule // fttor_regs_tb
